/* File: common/tma_pkg.sv */
// package: constants and carriers for the temperature monitor control block
package tma_pkg;
    localparam int          CLK_MHZ       = 250;
    localparam int          CONV_TIME_MS  = 125;
    localparam int          CONV_CYC      = CONV_TIME_MS * 1000 * CLK_MHZ;
    localparam int          TOUT_TIME_MS  = 37;
    localparam int          TOUT_CYC      = TOUT_TIME_MS * 1000 * CLK_MHZ;
    localparam int          AUTO_BASE_US  = 62500;
    localparam int          AUTO_BASE_CYC = AUTO_BASE_US * CLK_MHZ;
    localparam logic [2:0]  RATE_4HZ      = 3'h5;
    localparam logic [2:0]  RATE_MAX      = 3'h7;
    localparam logic [6:0]  ARA_ADDR      = 7'h0c;
    localparam logic [3:0]  BIT_LAST      = 4'h8;
    localparam logic [7:0]  STRAP_WAIT    = 8'h10;
    localparam logic [31:0] CNT_ONE       = 32'h0000_0001;

    typedef struct packed {
        logic signed [10:0] local_t;
        logic signed [10:0] remote_t;
    } tma_temps_type;

    typedef struct packed {
        logic signed [10:0] high;
        logic signed [10:0] low;
    } tma_limits_type;

    typedef enum logic [1:0] {CV_IDLE, CV_LOCAL, CV_REMOTE} tma_conv_type;
    typedef enum logic [1:0] {LK_ADDR, LK_SEND, LK_IGNORE} tma_link_type;
endpackage : tma_pkg

/* File: design/tma_ctrl.sv */
// module: conversion timing, alarms, standby, strap and serial timeouts
// What this block does
// R1: a stop-started conversion completes in 125 ms nominal, within 95 to 156 ms
// R2: at 4Hz or slower programmed rate the conversion takes twice as long
// R3: data line low 25 to 45 ms resets the serial interface
// R4: clock line low beyond the idle reset time also resets the serial interface
// R5: alert pin pulled low when a result leaves the high or low limit
// R6: alert stays low until status read or alert response answered
// R7: each overtemp pin pulls low only while temperature exceeds its threshold
// R8: the two overtemp pins compare independently against their own thresholds
// R9: sleep input low enters standby and suspends conversions
// R10: results and thresholds survive standby untouched
// R11: address strap high, low or open selects one of three addresses
// R12: after a timeout, release data, drop the transaction, wait for start
// R13: every conversion measures the local and then the remote channel
// R14: busy reads set during conversion while old results stay readable
// R15: 8Hz and 16Hz autonomous rates use 8-bit resolution only
module tma_ctrl #(
    parameter int         CONV_CYC      = tma_pkg::CONV_CYC,
    parameter int         TOUT_CYC      = tma_pkg::TOUT_CYC,
    parameter int         AUTO_BASE_CYC = tma_pkg::AUTO_BASE_CYC,
    parameter logic [6:0] ADDR_VCC      = 7'h4c,
    parameter logic [6:0] ADDR_GND      = 7'h4d,
    parameter logic [6:0] ADDR_OPEN     = 7'h4e
) (
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    serial_clock_pin_i,
    input  wire logic                    serial_data_pin_i,
    output logic                         serial_data_pin_o,
    output logic                         serial_data_pin_oe_o,
    input  wire logic                    hw_sleep_in_n_i,
    input  wire logic                    strap_high_i,
    input  wire logic                    strap_low_i,
    input  wire logic                    run_stop_i,
    input  wire logic [2:0]              rate_sel_i,
    input  wire logic                    one_shot_i,
    input  wire logic                    status_read_i,
    input  wire logic [10:0]             adc_value_i,
    input  wire tma_pkg::tma_limits_type limits_i,
    input  wire logic signed [10:0]      overtemp_first_lim_i,
    input  wire logic signed [10:0]      overtemp_second_lim_i,
    output tma_pkg::tma_temps_type       temps_o,
    output logic                         conv_busy_o,
    output logic                         conv_remote_o,
    output logic                         alert_oe_o,
    output logic                         overtemp_out_first_oe_o,
    output logic                         overtemp_out_second_oe_o,
    output logic [6:0]                   own_addr_o
);
    function automatic logic [10:0] fit(input logic [10:0] v, input logic leg);
        return leg ? {v[10:3], 3'h0} : v;
    endfunction : fit
    function automatic logic outside(input logic signed [10:0] t,
                                     input tma_pkg::tma_limits_type l);
        return (t > l.high) || (t < l.low);
    endfunction : outside
    function automatic logic hot(input tma_pkg::tma_temps_type t,
                                 input logic signed [10:0] l);
        return (t.local_t > l) || (t.remote_t > l);
    endfunction : hot

    // bus watch: synchronisers, start/stop, timeouts, strap, event return
    logic [4:0]  meta_reg,     sync_reg;
    logic        sda_prev_reg, armed_reg,    armed_next,   link_rst_reg, link_rst_next;
    logic [31:0] scl_low_reg,  scl_low_next, sda_low_reg,  sda_low_next;
    logic        tg_meta_reg,  tg_sync_reg,  tg_prev_reg,  ara_tgl_reg,  ara_tgl_next;
    logic [7:0]  strap_cnt_reg, strap_cnt_next;
    logic [6:0]  own_addr_reg, own_addr_next;
    logic        scl_s, sda_s, awake_s, start_w, stop_w, tout_w, ara_evt_w;

    assign scl_s     = sync_reg[4];
    assign sda_s     = sync_reg[3];
    assign awake_s   = sync_reg[2];
    assign start_w   = scl_s && sda_prev_reg && !sda_s;
    assign stop_w    = scl_s && !sda_prev_reg && sda_s;
    assign ara_evt_w = tg_sync_reg ^ tg_prev_reg;
    assign tout_w    = (!sda_s && sda_low_reg == 32'(TOUT_CYC - 1))  // R3
                    || (!scl_s && scl_low_reg == 32'(TOUT_CYC - 1)); // R4
    always_comb begin
        scl_low_next   = scl_s ? '0 : (scl_low_reg == 32'(TOUT_CYC - 1)) ? scl_low_reg
                                    : scl_low_reg + tma_pkg::CNT_ONE;
        sda_low_next   = sda_s ? '0 : (sda_low_reg == 32'(TOUT_CYC - 1)) ? sda_low_reg
                                    : sda_low_reg + tma_pkg::CNT_ONE;
        armed_next     = start_w ? 1'b1 : (stop_w || tout_w) ? 1'b0 : armed_reg;
        // link logic held in reset while idle, pulsed at every start
        link_rst_next  = !armed_next || start_w; // R12
        strap_cnt_next = strap_cnt_reg;
        own_addr_next  = own_addr_reg;
        if (strap_cnt_reg != tma_pkg::STRAP_WAIT) begin
            strap_cnt_next = strap_cnt_reg + 8'h01;
        end
        if (strap_cnt_reg == tma_pkg::STRAP_WAIT - 8'h01) begin
            own_addr_next = sync_reg[1] ? ADDR_VCC : sync_reg[0] ? ADDR_GND : ADDR_OPEN; // R11
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg      <= 5'h1f;
            sync_reg      <= 5'h1f;
            sda_prev_reg  <= 1'b1;
            scl_low_reg   <= '0;
            sda_low_reg   <= '0;
            armed_reg     <= 1'b0;
            link_rst_reg  <= 1'b1;
            tg_meta_reg   <= 1'b0;
            tg_sync_reg   <= 1'b0;
            tg_prev_reg   <= 1'b0;
            strap_cnt_reg <= '0;
            own_addr_reg  <= ADDR_OPEN;
        end else begin
            meta_reg      <= {serial_clock_pin_i, serial_data_pin_i, hw_sleep_in_n_i,
                              strap_high_i, strap_low_i};
            sync_reg      <= meta_reg;
            sda_prev_reg  <= sda_s;
            scl_low_reg   <= scl_low_next;
            sda_low_reg   <= sda_low_next;
            armed_reg     <= armed_next;
            link_rst_reg  <= link_rst_next;
            tg_meta_reg   <= ara_tgl_reg;
            tg_sync_reg   <= tg_meta_reg;
            tg_prev_reg   <= tg_sync_reg;
            strap_cnt_reg <= strap_cnt_next;
            own_addr_reg  <= own_addr_next;
        end
    end

    // conversion sequencer, results and alarms
    tma_pkg::tma_conv_type  cv_state_reg, cv_state_next;
    tma_pkg::tma_temps_type temps_reg,    temps_next;
    logic [31:0] cv_cnt_reg,  cv_cnt_next,  auto_cnt_reg, auto_cnt_next;
    logic        pend_reg,    pend_next,    slow_reg,     slow_next;
    logic        legacy_reg,  legacy_next,  alert_reg,    alert_next;
    logic        ot1_reg,     ot2_reg,      busy_reg,     remote_reg;
    logic        fast_w,      start_one_w,  start_auto_w, cap_l_w,    cap_r_w;
    logic [10:0] fit_w;
    assign fast_w       = rate_sel_i > tma_pkg::RATE_4HZ;
    assign start_one_w  = pend_reg && stop_w; // R1
    assign start_auto_w = !run_stop_i && auto_cnt_reg == '0;
    assign fit_w        = fit(adc_value_i, legacy_reg); // R15
    assign cap_l_w      = awake_s && cv_state_reg == tma_pkg::CV_LOCAL && cv_cnt_reg == 32'd1;
    assign cap_r_w      = awake_s && cv_state_reg == tma_pkg::CV_REMOTE && cv_cnt_reg == 32'd1;
    always_comb begin
        cv_state_next = cv_state_reg;
        cv_cnt_next   = cv_cnt_reg - tma_pkg::CNT_ONE;
        auto_cnt_next = (auto_cnt_reg == '0) ? auto_cnt_reg : auto_cnt_reg - tma_pkg::CNT_ONE;
        pend_next     = pend_reg || one_shot_i;
        slow_next     = slow_reg;
        legacy_next   = legacy_reg;
        temps_next    = temps_reg; // R10
        if (!awake_s) begin
            cv_state_next = tma_pkg::CV_IDLE; // R9
            cv_cnt_next   = cv_cnt_reg;
        end else begin
            unique case (cv_state_reg)
                tma_pkg::CV_IDLE: begin
                    cv_cnt_next = cv_cnt_reg;
                    if (start_one_w || start_auto_w) begin
                        cv_state_next = tma_pkg::CV_LOCAL; // R13
                        slow_next     = !fast_w;
                        legacy_next   = fast_w && !start_one_w; // R15
                        // each channel takes half; slow rates double the total
                        cv_cnt_next   = fast_w ? 32'(CONV_CYC / 2) : 32'(CONV_CYC); // R2
                        pend_next     = one_shot_i;
                    end
                    if (start_auto_w && !start_one_w) begin
                        auto_cnt_next = (32'(AUTO_BASE_CYC)
                                         << (tma_pkg::RATE_MAX - rate_sel_i)) - tma_pkg::CNT_ONE;
                    end
                end
                tma_pkg::CV_LOCAL: begin
                    if (cap_l_w) begin
                        temps_next.local_t = fit_w;
                        cv_state_next      = tma_pkg::CV_REMOTE; // R13
                        cv_cnt_next        = slow_reg ? 32'(CONV_CYC) : 32'(CONV_CYC / 2); // R1
                    end
                end
                tma_pkg::CV_REMOTE: begin
                    if (cap_r_w) begin
                        temps_next.remote_t = fit_w;
                        cv_state_next       = tma_pkg::CV_IDLE;
                    end
                end
                default: cv_state_next = tma_pkg::CV_IDLE;
            endcase
        end
        // a new excursion wins over an acknowledge in the same cycle
        alert_next = (cap_l_w && outside(fit_w, limits_i))
                  || (cap_r_w && outside(fit_w, limits_i))          // R5
                  || (alert_reg && !status_read_i && !ara_evt_w);   // R6
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cv_state_reg <= tma_pkg::CV_IDLE;
            cv_cnt_reg   <= '0;
            auto_cnt_reg <= '0;
            pend_reg     <= 1'b0;
            slow_reg     <= 1'b0;
            legacy_reg   <= 1'b0;
            temps_reg    <= '0;
            alert_reg    <= 1'b0;
            ot1_reg      <= 1'b0;
            ot2_reg      <= 1'b0;
            busy_reg     <= 1'b0;
            remote_reg   <= 1'b0;
        end else begin
            cv_state_reg <= cv_state_next;
            cv_cnt_reg   <= cv_cnt_next;
            auto_cnt_reg <= auto_cnt_next;
            pend_reg     <= pend_next;
            slow_reg     <= slow_next;
            legacy_reg   <= legacy_next;
            temps_reg    <= temps_next;
            alert_reg    <= alert_next;
            ot1_reg      <= hot(temps_reg, overtemp_first_lim_i);  // R7 R8
            ot2_reg      <= hot(temps_reg, overtemp_second_lim_i); // R7 R8
            busy_reg     <= cv_state_next != tma_pkg::CV_IDLE;     // R14
            remote_reg   <= cv_state_next == tma_pkg::CV_REMOTE;
        end
    end

    // link side: address byte, acknowledge, alert response transmit
    tma_pkg::tma_link_type lk_state_reg, lk_state_next;
    logic [3:0] lk_cnt_reg,   lk_cnt_next;
    logic [7:0] lk_shift_reg, lk_shift_next, tx_w;
    logic       al_meta_reg,  al_sync_reg,   sda_oe_reg,  sda_oe_next;
    logic       own_w,        ara_w,         lk_last_w;
    // own address is static once the strap is caught, long before traffic
    assign tx_w      = {own_addr_reg, 1'b0};
    assign own_w     = lk_shift_reg[7:1] == own_addr_reg;
    assign ara_w     = lk_shift_reg == {tma_pkg::ARA_ADDR, 1'b1} && al_sync_reg;
    assign lk_last_w = lk_cnt_reg == tma_pkg::BIT_LAST;
    always_comb begin
        lk_cnt_next   = lk_last_w ? 4'h0 : lk_cnt_reg + 4'h1;
        lk_shift_next = lk_shift_reg;
        lk_state_next = lk_state_reg;
        ara_tgl_next  = ara_tgl_reg;
        if (lk_state_reg == tma_pkg::LK_ADDR && !lk_last_w) begin
            lk_shift_next = {lk_shift_reg[6:0], serial_data_pin_i};
        end
        if (lk_last_w) begin
            lk_state_next = (lk_state_reg == tma_pkg::LK_ADDR && ara_w) ? tma_pkg::LK_SEND
                                                                          : tma_pkg::LK_IGNORE;
            ara_tgl_next  = ara_tgl_reg ^ (lk_state_reg == tma_pkg::LK_SEND); // R6
        end
        sda_oe_next = 1'b0;
        if (lk_state_reg == tma_pkg::LK_ADDR && lk_last_w) begin
            sda_oe_next = own_w || ara_w;
        end else if (lk_state_reg == tma_pkg::LK_SEND && !lk_last_w) begin
            sda_oe_next = !tx_w[3'(4'h7 - lk_cnt_reg)];
        end
    end

    always_ff @(posedge serial_clock_pin_i or posedge link_rst_reg) begin
        if (link_rst_reg) begin // R12
            lk_state_reg <= tma_pkg::LK_ADDR;
            lk_cnt_reg   <= '0;
            lk_shift_reg <= '0;
            al_meta_reg  <= 1'b0;
            al_sync_reg  <= 1'b0;
        end else begin
            lk_state_reg <= lk_state_next;
            lk_cnt_reg   <= lk_cnt_next;
            lk_shift_reg <= lk_shift_next;
            al_meta_reg  <= alert_reg;
            al_sync_reg  <= al_meta_reg;
        end
    end

    // toggle survives link resets so no false event reaches the alert latch
    always_ff @(posedge serial_clock_pin_i or posedge rst_i) begin
        if (rst_i) begin
            ara_tgl_reg <= 1'b0;
        end else begin
            ara_tgl_reg <= ara_tgl_next;
        end
    end

    always_ff @(negedge serial_clock_pin_i or posedge link_rst_reg) begin
        if (link_rst_reg) begin
            sda_oe_reg <= 1'b0; // R12
        end else begin
            sda_oe_reg <= sda_oe_next;
        end
    end

    assign serial_data_pin_o        = 1'b0;
    assign serial_data_pin_oe_o     = sda_oe_reg;
    assign temps_o                  = temps_reg;
    assign conv_busy_o              = busy_reg;
    assign conv_remote_o            = remote_reg;
    assign alert_oe_o               = alert_reg;
    assign overtemp_out_first_oe_o  = ot1_reg;
    assign overtemp_out_second_oe_o = ot2_reg;
    assign own_addr_o               = own_addr_reg;

    // conversion length seen from busy, for checking only
    logic [31:0] len_reg;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            len_reg <= '0;
        end else begin
            len_reg <= busy_reg ? len_reg + tma_pkg::CNT_ONE : '0;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_conv_length: assert property ($fell(busy_reg) && $past(awake_s) // R1 R2
        |-> len_reg == (slow_reg ? 32'(2 * CONV_CYC) : 32'(CONV_CYC)))
        else $error("conversion length wrong");
    a_sda_timeout: assert property (!sda_s && sda_low_reg == 32'(TOUT_CYC - 1) // R3
        |=> link_rst_reg) else $error("data-low timeout missed");
    a_scl_timeout: assert property (!scl_s && scl_low_reg == 32'(TOUT_CYC - 1) // R4
        |=> link_rst_reg ##1 !serial_data_pin_oe_o) else $error("clock-low timeout missed");
    a_alert_set: assert property ((cap_l_w || cap_r_w) && outside(fit_w, limits_i) // R5
        |=> alert_oe_o) else $error("alert not raised");
    a_alert_hold: assert property (alert_oe_o && !status_read_i && !ara_evt_w // R6
        |=> alert_oe_o) else $error("alert dropped early");
    a_ot_first: assert property (##1 overtemp_out_first_oe_o // R7
        == $past(hot(temps_reg, overtemp_first_lim_i))) else $error("overtemp one wrong");
    a_ot_second: assert property (##1 overtemp_out_second_oe_o // R8
        == $past(hot(temps_reg, overtemp_second_lim_i))) else $error("overtemp two wrong");
    a_sleep_halt: assert property (!awake_s |=> !conv_busy_o) // R9
        else $error("conversion ran asleep");
    a_results_kept: assert property (!cap_l_w && !cap_r_w |=> $stable(temps_reg)) // R10 R14
        else $error("results changed");
    a_both_chans: assert property (cap_l_w |=> conv_remote_o && conv_busy_o) // R13
        else $error("remote channel skipped");
    a_legacy_res: assert property (legacy_reg && cap_r_w // R15
        |=> temps_reg.remote_t[2:0] == 3'h0) else $error("fast rate kept fraction");

    c_conv_done: cover property ($fell(busy_reg) && awake_s);
    c_ara_answer: cover property (ara_evt_w && alert_oe_o);
    c_timeout: cover property (tout_w);
    c_alert_set: cover property ($rose(alert_oe_o));
endmodule : tma_ctrl

/* File: test/tma_host_model.sv */
// host controller model: drives the bus clock, pulls data low, reads the answers
module tma_host_model (
    output logic      scl_o,
    output logic      sda_oe_o,
    input  wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // bus clock stands high and data is released between frames
    initial begin
        scl_o    = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic start;
        #20 sda_oe_o = 1'b1;
        #20 scl_o = 1'b0;
    endtask : start

    // data set in clock low, held through the rising edge that samples it
    task automatic put_bit(input logic b, output logic r);
        sda_oe_o = ~b;
        #6 r = sda_i;
        scl_o = 1'b1;
        #6 scl_o = 1'b0;
    endtask : put_bit

    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                        output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            put_bit(tx[i], rx[i]);
        end
        put_bit(ack_in, b);
        ack = ~b;
    endtask : xfer

    task automatic stop;
        sda_oe_o = 1'b1;
        #6 scl_o = 1'b1;
        #20 sda_oe_o = 1'b0;
    endtask : stop
endmodule : tma_host_model

/* File: test/tb.sv */
// testbench: conversions, alarms, standby, strap and bus timeout of the control block
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CONV = 40;
    localparam int TOUT = 50;
    localparam int AUTO = 200;
    logic                    sys_clk_i, rst_i, scl, host_oe, sda, dev_oe, sda_o;
    logic                    hw_sleep_in_n_i, strap_high_i, strap_low_i, run_stop_i;
    logic                    one_shot_i, status_read_i, busy, remote, alert, ot1, ot2;
    logic [2:0]              rate_sel_i;
    logic [10:0]             adc_value_i, ot1_lim, ot2_lim;
    logic [6:0]              own_addr;
    logic [7:0]              rx;
    logic                    ack;
    tma_pkg::tma_limits_type limits_i;
    tma_pkg::tma_temps_type  temps_o;
    int                      err_count, checks;

    // open-drain data line with pull-up
    assign sda = ~(host_oe | dev_oe);

    tma_host_model i_tma_host_model (.scl_o(scl), .sda_oe_o(host_oe), .sda_i(sda));

    tma_ctrl #(.CONV_CYC(CONV), .TOUT_CYC(TOUT), .AUTO_BASE_CYC(AUTO)) i_tma_ctrl (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .serial_clock_pin_i(scl),
        .serial_data_pin_i(sda), .serial_data_pin_o(sda_o), .serial_data_pin_oe_o(dev_oe),
        .hw_sleep_in_n_i(hw_sleep_in_n_i), .strap_high_i(strap_high_i),
        .strap_low_i(strap_low_i), .run_stop_i(run_stop_i), .rate_sel_i(rate_sel_i),
        .one_shot_i(one_shot_i), .status_read_i(status_read_i), .adc_value_i(adc_value_i),
        .limits_i(limits_i), .overtemp_first_lim_i(ot1_lim), .overtemp_second_lim_i(ot2_lim),
        .temps_o(temps_o), .conv_busy_o(busy), .conv_remote_o(remote), .alert_oe_o(alert),
        .overtemp_out_first_oe_o(ot1), .overtemp_out_second_oe_o(ot2), .own_addr_o(own_addr));

    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    initial begin
        #100000;
        err_count++;
        give_verdict();
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : tick

    task automatic do_reset(input logic hi, input logic lo, input logic [6:0] exp);
        rst_i = 1'b1;
        strap_high_i = hi;
        strap_low_i = lo;
        tick(6);
        check(own_addr, 7'h4e);
        rst_i = 1'b0;
        tick(17);
        check(own_addr, exp);
        $display("test strap done");
    endtask : do_reset

    task automatic bus_addr(input logic [7:0] a, input logic exp_ack);
        i_tma_host_model.start();
        i_tma_host_model.xfer(a, 1'b1, rx, ack);
        i_tma_host_model.stop();
        check(ack, exp_ack);
    endtask : bus_addr

    // one-shot request, then an addressed frame whose stop launches it
    task automatic launch(input logic [2:0] rate, input logic [10:0] lv);
        int n;
        rate_sel_i = rate;
        adc_value_i = lv;
        one_shot_i = 1'b1;
        tick(1);
        one_shot_i = 1'b0;
        bus_addr(8'h9c, 1'b1);
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
    endtask : launch

    task automatic conv(input logic [2:0] rate, input int len, input logic [10:0] lv,
                        input logic [10:0] rv);
        int n;
        logic [21:0] old;
        old = temps_o;
        launch(rate, lv);
        n = 0;
        while (busy === 1'b1 && n < 1000) begin
            if (remote === 1'b1) adc_value_i = rv;
            if (n == 2) check(temps_o, old);
            tick(1);
            n++;
        end
        check(n, len);
        check(temps_o, {lv, rv});
        tick(2);
        $display("test conversion done");
    endtask : conv

    task automatic s_alert;
        limits_i.high = 11'h100;
        conv(3'h5, 2 * CONV, 11'h155, 11'h020);
        check({alert, ot1, ot2}, 3'b111);
        i_tma_host_model.start();
        i_tma_host_model.xfer(8'h19, 1'b1, rx, ack);
        check(ack, 1'b1);
        i_tma_host_model.xfer(8'hff, 1'b1, rx, ack);
        check(rx, 8'h9c);
        i_tma_host_model.stop();
        tick(8);
        check(alert, 1'b0);
        conv(3'h7, CONV, 11'h155, 11'h020);
        check(alert, 1'b1);
        status_read_i = 1'b1;
        tick(1);
        status_read_i = 1'b0;
        tick(2);
        check(alert, 1'b0);
        $display("test alert done");
    endtask : s_alert

    task automatic s_sleep;
        logic [21:0] old;
        old = temps_o;
        launch(3'h7, 11'h011);
        tick(5);
        hw_sleep_in_n_i = 1'b0;
        tick(6);
        check(busy, 1'b0);
        check(temps_o, old);
        hw_sleep_in_n_i = 1'b1;
        tick(4);
        $display("test standby done");
    endtask : s_sleep

    task automatic s_timeout;
        logic       r;
        logic [7:0] a;
        a = 8'h9c;
        // data held low by both sides: the data-low timeout fires first
        i_tma_host_model.start();
        for (int i = 7; i >= 0; i--) begin
            i_tma_host_model.put_bit(a[i], r);
        end
        tick(TOUT - 10);
        check({sda_o, dev_oe}, 2'b01);
        tick(16);
        check(dev_oe, 1'b0);
        i_tma_host_model.stop();
        bus_addr(8'h33, 1'b0);
        bus_addr(8'h9c, 1'b1);
        // clock parked low with data released: only the clock-low timeout can fire
        i_tma_host_model.start();
        for (int i = 7; i >= 2; i--) begin
            i_tma_host_model.put_bit(a[i], r);
        end
        tick(TOUT + 8);
        for (int i = 1; i >= 0; i--) begin
            i_tma_host_model.put_bit(a[i], r);
        end
        i_tma_host_model.put_bit(1'b1, r);
        check(r, 1'b1);
        i_tma_host_model.stop();
        $display("test timeout done");
    endtask : s_timeout

    task automatic s_auto;
        int n;
        adc_value_i = 11'h0f7;
        rate_sel_i = 3'h7;
        run_stop_i = 1'b0;
        n = 0;
        while (busy !== 1'b1 && n < 500) begin
            tick(1);
            n++;
        end
        check(busy, 1'b1);
        while (busy === 1'b1 && n < 1000) begin
            tick(1);
            n++;
        end
        check(temps_o, {11'h0f0, 11'h0f0});
        tick(2);
        check({alert, ot1, ot2}, 3'b000);
        run_stop_i = 1'b1;
        $display("test autonomous done");
    endtask : s_auto

    initial begin
        rst_i = 1'b1;
        hw_sleep_in_n_i = 1'b1;
        strap_high_i = 1'b0;
        strap_low_i = 1'b0;
        run_stop_i = 1'b1;
        one_shot_i = 1'b0;
        status_read_i = 1'b0;
        rate_sel_i = 3'h7;
        adc_value_i = 11'h000;
        limits_i = {11'h3f0, 11'h700};
        ot1_lim = 11'h0f0;
        ot2_lim = 11'h100;
        err_count = 0;
        checks = 0;
        do_reset(1'b1, 1'b0, 7'h4c);
        do_reset(1'b0, 1'b1, 7'h4d);
        do_reset(1'b0, 1'b0, 7'h4e);
        conv(3'h7, CONV, 11'h0f3, 11'h0a5);
        check({alert, ot1, ot2}, 3'b010);
        s_alert();
        s_sleep();
        s_timeout();
        s_auto();
        give_verdict();
    end
endmodule : tb
